// File: common/bseec_cfg.svh
// bit serial eeprom control: offsets, field positions and counts
`ifndef BSEEC_CFG_SVH
`define BSEEC_CFG_SVH
`define BSEEC_IDX_SEL 8'h0e
`define BSEEC_IDX_CTL 8'h0f
`define BSEEC_SEL_RST 8'h00
`define BSEEC_CTL_FCOL 0
`define BSEEC_CTL_CPCLK 2
`define BSEEC_CTL_PEN 3
`define BSEEC_CTL_ROW 4
`define BSEEC_CTL_PGM 5
`define BSEEC_CTL_BULK 6
`define BSEEC_CTL_SENSE 7
`define BSEEC_RESP_OK 2'h0
`define BSEEC_RESP_ERR 2'h2
`define BSEEC_ARRAY_BITS 128
`define BSEEC_ROW_BITS 8
`define BSEEC_LAST_BIT 7'h7f
`define BSEEC_EDGE_IGN 2'h0
`define BSEEC_EDGE_OPHI 2'h1
`define BSEEC_EDGE_OPLO 2'h2
`endif

// File: common/bseec_pkg.sv
// bit serial eeprom control: shared types
package bseec_pkg;
    typedef enum logic [1:0] {
        BSEEC_S_SEL = 2'b00,
        BSEEC_S_DATA = 2'b01,
        BSEEC_S_DONE = 2'b10
    } bseec_state_t;
    typedef enum logic [1:0] {
        BSEEC_OP_PROG = 2'b00,
        BSEEC_OP_READ = 2'b01,
        BSEEC_OP_NONE = 2'b10,
        BSEEC_OP_BULK = 2'b11
    } bseec_op_t;
    typedef struct packed {
        logic wr;
        logic clr_all;
        logic [6:0] wr_addr;
        logic [6:0] rd_addr;
    } bseec_ser_req_t;
endpackage

// File: core/bseec_serial.sv
// bit serial eeprom control: serial programming engine
`timescale 1ns/1ps
`include "bseec_cfg.svh"
module bseec_serial
    import bseec_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ser_mode_pin,
    input wire logic ser_resetn_pin,
    input wire logic sel_clk_pin,
    input wire logic data_pin_in,
    input wire logic rd_bit,
    output logic data_pin_out,
    output logic data_pin_oe_n,
    output bseec_ser_req_t req
);
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic sel_prev_ff;
    bseec_state_t state_ff;
    bseec_state_t nxt_state;
    bseec_op_t op_ff;
    logic op_hi_ff;
    logic [1:0] edge_ff;
    logic [6:0] addr_ff;
    logic out_ff;
    logic oe_n_ff;
    logic wr_ff;
    logic clr_ff;
    logic [6:0] wr_addr_ff;

    // mode, reset, select clock and data all arrive from the pins
    wire active = sync2_ff[3] & sync2_ff[2];
    wire sel_s = sync2_ff[1];
    wire data_s = sync2_ff[0];
    wire fall = active & sel_prev_ff & ~sel_s;
    wire in_sel = state_ff == BSEEC_S_SEL;
    wire sel_done = fall & in_sel & (edge_ff == `BSEEC_EDGE_OPLO);
    wire [1:0] op_bits = {op_hi_ff, data_s};
    wire bseec_op_t op_now = bseec_op_t'(op_bits);
    wire moves_data = op_now == BSEEC_OP_PROG || op_now == BSEEC_OP_READ;
    wire last = addr_ff == `BSEEC_LAST_BIT;
    wire in_data = state_ff == BSEEC_S_DATA;
    wire bseec_op_t nxt_op = sel_done ? op_now : op_ff;
    wire nxt_op_hi = (fall & in_sel & (edge_ff == `BSEEC_EDGE_OPHI))
        ? data_s : op_hi_ff;
    wire [1:0] nxt_edge = !active ? `BSEEC_EDGE_IGN
        : (fall & in_sel) ? edge_ff + 2'h1 : edge_ff;
    wire [6:0] nxt_addr = !active ? 7'h00
        : (fall & in_data) ? addr_ff + 7'h01 : addr_ff;
    // a zero data bit leaves the erased cell alone
    wire nxt_wr = fall & in_data & (op_ff == BSEEC_OP_PROG) & data_s;
    wire nxt_clr = sel_done & (op_now == BSEEC_OP_BULK);
    wire nxt_oe_n = !(nxt_state == BSEEC_S_DATA
        && nxt_op == BSEEC_OP_READ);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            BSEEC_S_SEL: if (sel_done) begin
                nxt_state = moves_data ? BSEEC_S_DATA : BSEEC_S_DONE;
            end
            BSEEC_S_DATA: if (fall && last) begin
                nxt_state = BSEEC_S_DONE;
            end
            BSEEC_S_DONE: nxt_state = BSEEC_S_DONE;
            default: nxt_state = BSEEC_S_SEL;
        endcase
        if (!active) begin
            nxt_state = BSEEC_S_SEL;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
            sel_prev_ff <= 1'b0;
        end else begin
            sync1_ff <= {ser_mode_pin, ser_resetn_pin, sel_clk_pin,
                data_pin_in};
            sync2_ff <= sync1_ff;
            sel_prev_ff <= sel_s;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= BSEEC_S_SEL;
            op_ff <= BSEEC_OP_NONE;
            op_hi_ff <= 1'b0;
            edge_ff <= `BSEEC_EDGE_IGN;
            addr_ff <= 7'h00;
            wr_ff <= 1'b0;
            clr_ff <= 1'b0;
            wr_addr_ff <= 7'h00;
            out_ff <= 1'b0;
            oe_n_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            op_hi_ff <= nxt_op_hi;
            edge_ff <= nxt_edge;
            addr_ff <= nxt_addr;
            wr_ff <= nxt_wr;
            clr_ff <= nxt_clr;
            wr_addr_ff <= addr_ff;
            out_ff <= rd_bit;
            oe_n_ff <= nxt_oe_n;
        end
    end

    assign data_pin_out = out_ff;
    assign data_pin_oe_n = oe_n_ff;
    assign req = '{wr: wr_ff, clr_all: clr_ff, wr_addr: wr_addr_ff,
        rd_addr: addr_ff};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence bulk_cmd_s;
        sel_done && op_hi_ff && data_s;
    endsequence
    ser_bulk_a: assert property (bulk_cmd_s |=> req.clr_all)
        else $error("bulk code did not clear array");
    first_ign_a: assert property (fall && in_sel
        && edge_ff == `BSEEC_EDGE_IGN |=> op_hi_ff == $past(op_hi_ff))
        else $error("first select bit was used");
    prog_bit_a: assert property (fall && in_data
        && op_ff == BSEEC_OP_PROG && data_s
        |=> req.wr && req.wr_addr == $past(addr_ff))
        else $error("serial program bit not written");
    data_end_a: assert property (fall && in_data && last
        |=> state_ff == BSEEC_S_DONE)
        else $error("data phase not ended after last bit");
    unassigned_a: assert property (op_ff == BSEEC_OP_NONE
        |-> !req.wr && !req.clr_all)
        else $error("unassigned code touched array");
    read_drive_a: assert property (
        data_pin_oe_n == !(in_data && op_ff == BSEEC_OP_READ))
        else $error("data pin drive wrong for operation");
endmodule

// File: core/bseec_top.sv
// bit serial eeprom control: registers, array and sense path
// Function
// - bulk erase bit high clears whole array regardless of select
// - row erase together with bulk erase acts as bulk erase
// - bulk erase bit is read/write and cleared by reset
// - sense bit is read-only, shows selected array bit
// - sense bit valid only with program, erase and pump enable bits low
// - right after reset sense bit shows array bit zero
// - incrementing select wraps column into next row, column zero
// - bit select reads back the last byte written
// - serial mode uses reset, data and select clock pins
// - serial data sampled after each falling select clock edge
// - first select bit ignored, next two choose the operation
// - program and read-out move 128 bits, one per falling edge
// - program bit with pump running writes one to selected bit
// - row erase clears the eight bits of the selected row
// - first column flag is one exactly at column zero, set by reset
// - pump runs only with enable and an active program or erase
`timescale 1ns/1ps
`include "bseec_cfg.svh"
module bseec_top
    import bseec_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ser_mode_pin,
    input wire logic ser_resetn_pin,
    input wire logic sel_clk_pin,
    input wire logic serial_data_pin_in,
    output logic serial_data_pin_out,
    output logic serial_data_pin_oe_n,
    output logic pump_active,
    output logic pump_clk_bus
);
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_chk
        $error("ADDR_W must lie between 8 and 32");
    end

    localparam logic [ADDR_W-1:0] SEL_ADDR =
        ADDR_W'({`BSEEC_IDX_SEL, 2'h0});
    localparam logic [ADDR_W-1:0] CTL_ADDR =
        ADDR_W'({`BSEEC_IDX_CTL, 2'h0});

    // {control hit, select hit}; low two address bits are ignored
    function automatic logic [1:0] reg_dec(input logic [ADDR_W-1:0] a);
        reg_dec = {a[ADDR_W-1:2] == CTL_ADDR[ADDR_W-1:2],
            a[ADDR_W-1:2] == SEL_ADDR[ADDR_W-1:2]};
    endfunction

    logic [`BSEEC_ARRAY_BITS-1:0] array_ff;
    logic [7:0] sel_ff;
    logic cpclk_ff;
    logic pen_ff;
    logic row_ff;
    logic pgm_ff;
    logic bulk_ff;
    logic aw_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic w_ff;
    logic [7:0] wdata_ff;
    logic wstrb0_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [7:0] ctl_rd;
    bseec_ser_req_t ser_req;

    // array side
    wire [6:0] sel_idx = sel_ff[6:0];
    wire [6:0] row_base = {sel_ff[6:3], 3'h0};
    wire [`BSEEC_ROW_BITS-1:0] row_bits =
        array_ff[row_base +: `BSEEC_ROW_BITS];
    wire any_op = pgm_ff | row_ff | bulk_ff;
    wire pump_run = pen_ff & any_op;
    wire sense_ok = !(any_op | pen_ff);
    wire sense_raw = array_ff[sel_idx];
    // masking avoids showing a cell that is being stressed
    wire sense_bit = sense_ok & sense_raw;
    wire first_col = sel_ff[2:0] == 3'h0;
    wire ser_rd_bit = array_ff[ser_req.rd_addr];

    bseec_serial u_serial (
        .clk(clk),
        .resetn(resetn),
        .ser_mode_pin(ser_mode_pin),
        .ser_resetn_pin(ser_resetn_pin),
        .sel_clk_pin(sel_clk_pin),
        .data_pin_in(serial_data_pin_in),
        .rd_bit(ser_rd_bit),
        .data_pin_out(serial_data_pin_out),
        .data_pin_oe_n(serial_data_pin_oe_n),
        .req(ser_req)
    );

    // write channel: address and data taken in either order
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire wr_go = aw_ff & w_ff;
    wire [1:0] wr_dec = reg_dec(awaddr_ff);
    wire wr_en = wr_go & wstrb0_ff;
    wire sel_we = wr_en & wr_dec[0];
    wire ctl_we = wr_en & wr_dec[1];
    wire [1:0] nxt_bresp = (|wr_dec) ? `BSEEC_RESP_OK : `BSEEC_RESP_ERR;
    wire nxt_aw = !wr_go & (aw_ff | aw_take);
    wire nxt_w = !wr_go & (w_ff | w_take);
    wire nxt_bvalid = wr_go | (bvalid_ff & !s_axi_bready);

    assign s_axi_awready = !aw_ff & !bvalid_ff;
    assign s_axi_wready = !w_ff & !bvalid_ff;

    // read channel
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire [1:0] rd_dec = reg_dec(s_axi_araddr);
    wire [31:0] rd_val = rd_dec[0] ? {24'h0, sel_ff}
        : rd_dec[1] ? {24'h0, ctl_rd} : 32'h0;
    wire [1:0] nxt_rresp = (|rd_dec) ? `BSEEC_RESP_OK : `BSEEC_RESP_ERR;
    wire nxt_rvalid = ar_take | (rvalid_ff & !s_axi_rready);

    assign s_axi_arready = !rvalid_ff;

    always_comb begin
        ctl_rd = 8'h00;
        ctl_rd[`BSEEC_CTL_FCOL] = first_col;
        ctl_rd[`BSEEC_CTL_CPCLK] = cpclk_ff;
        ctl_rd[`BSEEC_CTL_PEN] = pen_ff;
        ctl_rd[`BSEEC_CTL_ROW] = row_ff;
        ctl_rd[`BSEEC_CTL_PGM] = pgm_ff;
        ctl_rd[`BSEEC_CTL_BULK] = bulk_ff;
        ctl_rd[`BSEEC_CTL_SENSE] = sense_bit;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_ff <= 1'b0;
            awaddr_ff <= '0;
            w_ff <= 1'b0;
            wdata_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `BSEEC_RESP_OK;
        end else begin
            aw_ff <= nxt_aw;
            w_ff <= nxt_w;
            bvalid_ff <= nxt_bvalid;
            if (aw_take) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_ff <= s_axi_wdata[7:0];
                wstrb0_ff <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                bresp_ff <= nxt_bresp;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= `BSEEC_RESP_OK;
        end else begin
            rvalid_ff <= nxt_rvalid;
            if (ar_take) begin
                rdata_ff <= rd_val;
                rresp_ff <= nxt_rresp;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sel_ff <= `BSEEC_SEL_RST;
            cpclk_ff <= 1'b0;
            pen_ff <= 1'b0;
            row_ff <= 1'b0;
            pgm_ff <= 1'b0;
            bulk_ff <= 1'b0;
        end else begin
            if (sel_we) begin
                sel_ff <= wdata_ff;
            end
            if (ctl_we) begin
                cpclk_ff <= wdata_ff[`BSEEC_CTL_CPCLK];
                pen_ff <= wdata_ff[`BSEEC_CTL_PEN];
                row_ff <= wdata_ff[`BSEEC_CTL_ROW];
                pgm_ff <= wdata_ff[`BSEEC_CTL_PGM];
                bulk_ff <= wdata_ff[`BSEEC_CTL_BULK];
            end
        end
    end

    // cells are nonvolatile, so the array has no reset
    always_ff @(posedge clk) begin
        if (ser_req.clr_all || bulk_ff) begin
            array_ff <= '0;
        end else if (row_ff) begin
            array_ff[row_base +: `BSEEC_ROW_BITS] <= '0;
        end else if (pump_run && pgm_ff) begin
            array_ff[sel_idx] <= 1'b1;
        end
        if (ser_req.wr) begin
            array_ff[ser_req.wr_addr] <= 1'b1;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    // pump follows control bits directly; no startup model here
    assign pump_active = pump_run;
    assign pump_clk_bus = cpclk_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence ctl_read_s;
        ar_take && rd_dec[1];
    endsequence
    sequence ops_cleared_s;
        ctl_we && !wdata_ff[`BSEEC_CTL_PGM] && !wdata_ff[`BSEEC_CTL_ROW]
            && !wdata_ff[`BSEEC_CTL_BULK];
    endsequence

    bulk_clear_a: assert property (bulk_ff && !ser_req.wr
        |=> array_ff == '0)
        else $error("bulk erase left bits set");
    row_bulk_a: assert property (row_ff && bulk_ff && !ser_req.wr
        |=> array_ff == '0)
        else $error("row plus bulk did not erase array");
    bulk_reset_a: assert property (@(posedge clk) disable iff (1'b0)
        !resetn |-> !bulk_ff)
        else $error("bulk bit set during reset");
    sense_read_a: assert property (ctl_read_s and sense_ok
        |=> rdata_ff[`BSEEC_CTL_SENSE] == $past(sense_raw))
        else $error("sense bit differs from selected cell");
    sense_mask_a: assert property (ctl_read_s and !sense_ok
        |=> !rdata_ff[`BSEEC_CTL_SENSE])
        else $error("sense bit shown while not valid");
    reset_sense_a: assert property ($rose(resetn)
        |-> sel_idx == 7'h00 && sense_ok)
        else $error("sense after reset not cell zero");
    sel_echo_a: assert property (sel_we
        |=> sel_ff == $past(wdata_ff))
        else $error("select did not read back written byte");
    pgm_set_a: assert property (pgm_ff && pump_run && !row_ff
        && !bulk_ff && !ser_req.clr_all |=> array_ff[$past(sel_idx)])
        else $error("program did not set selected cell");
    row_clear_a: assert property (row_ff && !bulk_ff && !sel_we
        && !ser_req.clr_all && !ser_req.wr |=> row_bits == 8'h00)
        else $error("row erase left bits set");
    first_col_a: assert property (ctl_read_s
        |=> rdata_ff[`BSEEC_CTL_FCOL] == ($past(sel_ff[2:0]) == 3'h0))
        else $error("first column flag wrong");
    pump_off_a: assert property (ops_cleared_s |=> !pump_active)
        else $error("pump kept running after ops cleared");
    wr_resp_a: assert property (wr_go |=> s_axi_bvalid
        && (s_axi_bresp == `BSEEC_RESP_OK) == $past(|wr_dec))
        else $error("write response wrong");
endmodule

// File: testbench/bseec_prog_model.sv
// external serial programmer model for the eeprom serial mode
`timescale 1ns/1ps
module bseec_prog_model
    import bseec_pkg::*;
(
    output logic ser_mode_pin,
    output logic ser_resetn_pin,
    output logic sel_clk_pin,
    output logic drv_en,
    output logic drv_val,
    input wire logic pin_level,
    input wire logic dev_oe_n
);
    localparam real HALF_NS = 62.5;
    initial begin
        ser_mode_pin = 1'b0;
        ser_resetn_pin = 1'b0;
        sel_clk_pin = 1'b0;
        drv_en = 1'b1;
        drv_val = 1'b0;
    end
    // data is set while the select line is high and held past the fall
    task automatic fall(input logic d, input logic stay, output logic q,
                        output logic o);
        begin
            drv_val = d;
            #(HALF_NS);
            q = pin_level;
            o = dev_oe_n;
            sel_clk_pin = 1'b0;
            #(HALF_NS);
            if (!stay) begin
                sel_clk_pin = 1'b1;
            end
        end
    endtask
    task automatic frame(input logic [1:0] op, input logic [127:0] wb,
                         output logic [127:0] rb, output logic oe_ok);
        logic q;
        logic o;
        logic rd;
        int i;
        begin
            rd = (op == BSEEC_OP_READ);
            oe_ok = 1'b1;
            rb = '0;
            drv_en = 1'b1;
            drv_val = 1'b0;
            sel_clk_pin = 1'b0;
            ser_resetn_pin = 1'b0;
            ser_mode_pin = 1'b1;
            #100;
            sel_clk_pin = 1'b1;
            #160;
            ser_resetn_pin = 1'b1;
            // data stays low for twenty bus clocks after reset release
            #200;
            fall(1'b0, 1'b0, q, o);
            oe_ok &= o;
            fall(op[1], 1'b0, q, o);
            oe_ok &= o;
            fall(op[0], op == BSEEC_OP_BULK, q, o);
            oe_ok &= o;
            if (op == BSEEC_OP_PROG || rd) begin
                for (i = 0; i < 128; i++) begin
                    drv_en = !rd;
                    fall(wb[i], 1'b0, q, o);
                    rb[i] = q;
                    oe_ok &= (o === !rd);
                end
            end
            #300;
            ser_resetn_pin = 1'b0;
            #100;
            ser_mode_pin = 1'b0;
            sel_clk_pin = 1'b0;
            drv_en = 1'b1;
            drv_val = 1'b0;
        end
    endtask
endmodule

// File: testbench/bseec_bench.sv
// self-checking bench: register bus and serial programmer scenarios
`timescale 1ns/1ps
`include "bseec_cfg.svh"
module bseec_bench
    import bseec_pkg::*;
;
    // register byte address is four times the documented index
    localparam logic [7:0] A_SEL = 8'h38;
    localparam logic [7:0] A_CTL = 8'h3c;
    localparam logic [1:0] OK = `BSEEC_RESP_OK;
    localparam logic [1:0] ERR = `BSEEC_RESP_ERR;
    logic clk;
    logic resetn;
    logic [7:0] s_axi_awaddr;
    logic [7:0] s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [31:0] s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp;
    logic [1:0] s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic ser_mode_pin, ser_resetn_pin, sel_clk_pin, data_wire;
    logic data_out, data_oe_n, drv_en, drv_val, float_ff;
    logic pump_active, pump_clk_bus, oe_ok;
    logic [127:0] exp_arr;
    logic [127:0] rb;
    logic [127:0] pat;
    logic [7:0] d;
    logic [7:0] pg [5] = '{8'h00, 8'h07, 8'h08, 8'h45, 8'h7f};
    int error_cnt = 0;
    int num_checks = 0;
    int i;

    // an undriven line shows a changing level, never the last value
    assign data_wire = !data_oe_n ? data_out : (drv_en ? drv_val : float_ff);
    always_ff @(posedge clk) float_ff <= ~data_wire;

    bseec_top #(.ADDR_W(8)) bseec_top_inst (
        .clk(clk), .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .ser_mode_pin(ser_mode_pin),
        .ser_resetn_pin(ser_resetn_pin), .sel_clk_pin(sel_clk_pin),
        .serial_data_pin_in(data_wire), .serial_data_pin_out(data_out),
        .serial_data_pin_oe_n(data_oe_n), .pump_active(pump_active),
        .pump_clk_bus(pump_clk_bus)
    );
    bseec_prog_model bseec_prog_model_inst (
        .ser_mode_pin(ser_mode_pin), .ser_resetn_pin(ser_resetn_pin),
        .sel_clk_pin(sel_clk_pin), .drv_en(drv_en), .drv_val(drv_val),
        .pin_level(data_wire), .dev_oe_n(data_oe_n)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        begin
            num_checks++;
            if (seen !== exp) begin
                error_cnt++;
                $display("wrong value at %0t: %s seen %h expected %h",
                         $time, what, seen, exp);
            end
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v,
                      input logic [1:0] er);
        logic pa;
        logic pw;
        logic ta;
        logic tw;
        int n;
        begin
            pa = 1'b1;
            pw = 1'b1;
            n = 0;
            @(posedge clk);
            s_axi_awaddr <= a;
            s_axi_awvalid <= 1'b1;
            s_axi_wdata <= {24'h000000, v};
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            while ((pa || pw) && n < 50) begin
                @(negedge clk);
                ta = pa && s_axi_awready === 1'b1;
                tw = pw && s_axi_wready === 1'b1;
                n++;
                @(posedge clk);
                if (ta) begin
                    s_axi_awvalid <= 1'b0;
                    pa = 1'b0;
                end
                if (tw) begin
                    s_axi_wvalid <= 1'b0;
                    pw = 1'b0;
                end
            end
            do begin
                @(negedge clk);
                n++;
            end while (s_axi_bvalid !== 1'b1 && n < 100);
            chk(n < 100, 1, "write answer in time");
            chk(s_axi_bresp, er, "write response");
            @(posedge clk);
            s_axi_bready <= 1'b0;
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v,
                      input logic [1:0] er);
        int n;
        begin
            n = 0;
            @(posedge clk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do begin
                @(negedge clk);
                n++;
            end while (s_axi_arready !== 1'b1 && n < 50);
            @(posedge clk);
            s_axi_arvalid <= 1'b0;
            do begin
                @(negedge clk);
                n++;
            end while (s_axi_rvalid !== 1'b1 && n < 100);
            chk(n < 100, 1, "read answer in time");
            chk(s_axi_rresp, er, "read response");
            chk(s_axi_rdata[31:8], 0, "read upper bits");
            v = s_axi_rdata[7:0];
            @(posedge clk);
            s_axi_rready <= 1'b0;
        end
    endtask

    task automatic sweep(input string what);
        logic [7:0] v;
        begin
            for (int a = 127; a >= 0; a--) begin
                wr(A_SEL, a[7:0], OK);
                rd(A_CTL, v, OK);
                chk(v[7], exp_arr[a], what);
            end
        end
    endtask

    task automatic tend(input string what);
        $display("test %s finished", what);
    endtask

    task automatic stop_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, error_cnt);
            if (error_cnt == 0 && num_checks > 0) begin
                $display("Regression OK");
            end else begin
                $display("Regression broken");
            end
            $finish;
        end
    endtask

    initial begin
        #500000;
        error_cnt++;
        $display("wrong value at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        resetn = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'h1;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        rd(A_SEL, d, OK);
        chk(d, 8'h00, "select after reset");
        chk(pump_active, 0, "pump after reset");
        wr(A_SEL, 8'h30, OK);
        wr(A_CTL, 8'h48, OK);
        chk(pump_active, 1, "pump with erase");
        wr(A_CTL, 8'h08, OK);
        chk(pump_active, 0, "pump enable alone");
        wr(A_CTL, 8'h00, OK);
        rd(A_CTL, d, OK);
        chk(d, 8'h01, "control after erase");
        tend("reset");
        exp_arr = '0;
        sweep("bulk erase");
        tend("bulk erase");
        wr(A_SEL, 8'ha5, OK);
        rd(A_SEL, d, OK);
        chk(d, 8'ha5, "select readback");
        wr(A_SEL, 8'h07, OK);
        rd(A_CTL, d, OK);
        chk(d[0], 0, "flag at last column");
        wr(A_SEL, 8'h08, OK);
        rd(A_CTL, d, OK);
        chk(d[0], 1, "flag after carry");
        wr(8'h20, 8'h11, ERR);
        rd(8'h20, d, ERR);
        chk(d, 8'h00, "unmapped read data");
        // sense, flag and bit one ignore writes; only pump clock sticks
        wr(A_CTL, 8'h87, OK);
        rd(A_CTL, d, OK);
        chk(d, 8'h05, "control readback");
        chk(pump_clk_bus, 1, "pump clock source");
        wr(A_CTL, 8'h00, OK);
        tend("registers");
        foreach (pg[k]) begin
            wr(A_SEL, pg[k], OK);
            wr(A_CTL, 8'h28, OK);
            wr(A_CTL, 8'h00, OK);
            exp_arr[pg[k]] = 1'b1;
        end
        wr(A_SEL, 8'h03, OK);
        wr(A_CTL, 8'h20, OK);
        wr(A_CTL, 8'h00, OK);
        wr(A_SEL, 8'h00, OK);
        wr(A_CTL, 8'h08, OK);
        rd(A_CTL, d, OK);
        chk(d[7], 0, "sense with pump enable");
        wr(A_CTL, 8'h00, OK);
        sweep("program");
        tend("program");
        wr(A_SEL, 8'h41, OK);
        wr(A_CTL, 8'h10, OK);
        wr(A_CTL, 8'h00, OK);
        exp_arr[64+:8] = 8'h00;
        sweep("row erase");
        wr(A_SEL, 8'h00, OK);
        wr(A_CTL, 8'h50, OK);
        wr(A_CTL, 8'h00, OK);
        exp_arr = '0;
        sweep("row with bulk");
        tend("erase");
        wr(A_CTL, 8'h28, OK);
        wr(A_CTL, 8'h00, OK);
        wr(A_SEL, 8'h09, OK);
        resetn <= 1'b0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        rd(A_CTL, d, OK);
        chk(d, 8'h81, "sense of bit zero after reset");
        tend("second reset");
        for (i = 0; i < 128; i++) begin
            pat[i] = (i % 3 == 0);
        end
        bseec_prog_model_inst.frame(BSEEC_OP_BULK, '0, rb, oe_ok);
        chk(oe_ok, 1, "pin released in bulk erase");
        wr(A_SEL, 8'h00, OK);
        rd(A_CTL, d, OK);
        chk(d[7], 0, "bit zero after serial erase");
        bseec_prog_model_inst.frame(BSEEC_OP_PROG, pat, rb, oe_ok);
        chk(oe_ok, 1, "pin released in program");
        exp_arr = pat;
        sweep("serial program");
        bseec_prog_model_inst.frame(BSEEC_OP_NONE, '1, rb, oe_ok);
        chk(oe_ok, 1, "pin released in unassigned");
        bseec_prog_model_inst.frame(BSEEC_OP_READ, '0, rb, oe_ok);
        chk(oe_ok, 1, "pin driven in read-out");
        for (i = 0; i < 4; i++) begin
            chk(rb[32*i+:32], exp_arr[32*i+:32], "serial read-out");
        end
        tend("serial");
        stop_test();
    end
endmodule
